// file: design/cxe_core.sv
// instruction execute unit: decodes resolved operations and updates state
// assumes operands are resolved upstream and data memory reads answer
// combinationally for the address that this unit drives
//
// What this block does
// - copy writes source, flags untouched
// - sum and sum with carry, all flags
// - differences via inverted source plus one/carry
// - compare and mask test only set flags
// - decimal sum with carry, overflow cleared
// - exclusive or and conjunction with flag rules
// - clear mask; both mask ops keep flags
// - rotate right through carry, seventeen-bit ring, nine-bit in byte mode
// - arithmetic right shift keeps top bit
// - stack store: pointer minus two, write
// - byte swap exchanges bytes, flags kept
// - subroutine entry pushes return, loads counter
// - interrupt return pops status then counter
// - sleep flag never saved on interrupt entry
// - sign extend copies bit seven upward
// - jump adds doubled signed offset plus two
// - register pair one cycle, two to counter
// - indexed pair and immediate cycle figures
// - jump, return and entry cycle figures
// - status bits at masks 1,2,4,8
// - width select zero word, one byte
//
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/10ps
module cxe_core
  import cxe_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // register bus slave
  input wire logic i_hsel,
  input wire logic [7:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // operation issue
  input wire logic i_op_valid,
  input wire logic [15:0] i_op_instr,
  input wire logic [15:0] i_op_src,
  input wire logic [15:0] i_op_dst,
  input wire logic i_irq_req,
  input wire logic [15:0] i_irq_vec,
  output logic o_op_ready,
  // result write-back
  output logic o_res_valid,
  output logic o_res_we,
  output logic [3:0] o_res_reg,
  output logic [15:0] o_res_data,
  // data memory port
  output logic [15:0] o_mem_addr,
  output logic [15:0] o_mem_wdata,
  output logic o_mem_we,
  output logic o_mem_re,
  input wire logic [15:0] i_mem_rdata,
  // core state
  output logic [15:0] o_pc,
  output logic [15:0] o_sp,
  output logic [15:0] o_sr
);

  // alu answer: result, new flags and a write flag
  typedef struct packed {
    logic [15:0] res;
    logic v, n, z, c;
    logic fl;
    logic wr;
  } cxe_alu_t;

  // width-aware helpers
  function automatic logic msb(input logic [15:0] x, input logic b);
    msb = b ? x[7] : x[15];
  endfunction
  function automatic logic [15:0] fit(input logic [15:0] x, input logic b);
    fit = b ? {8'h00, x[7:0]} : x;
  endfunction

  // common flag fill for logic style results
  function automatic cxe_alu_t nzc(input logic [15:0] r, input logic b);
    cxe_alu_t a;
    a = '0;
    a.res = fit(r, b);
    a.n = msb(a.res, b);
    a.z = (a.res == 16'h0000);
    a.c = ~a.z;
    a.fl = 1'b1;
    a.wr = 1'b1;
    return a;
  endfunction

  // dual-operand evaluation
  function automatic cxe_alu_t dual(input logic [3:0] op,
      input logic [15:0] s, input logic [15:0] d,
      input logic ci, input logic b);
    cxe_alu_t a;
    logic [15:0] sx;
    logic [16:0] sum;
    logic cin;
    logic [4:0] nib;
    logic dc;
    a = '0;
    sx = fit(s, b);
    cin = 1'b0;
    sum = '0;
    nib = '0;
    dc = ci;
    case (op)
      OP_COPY: begin
        a.res = fit(s, b);
        a.wr = 1'b1;
      end
      OP_SUM, OP_SUMC, OP_DIFF, OP_DIFB, OP_CMP: begin
        if (op == OP_DIFF || op == OP_DIFB || op == OP_CMP) begin
          sx = fit(~s, b);
        end
        if (op == OP_DIFF || op == OP_CMP) begin
          cin = 1'b1;
        end else if (op == OP_SUMC || op == OP_DIFB) begin
          cin = ci;
        end
        sum = {1'b0, fit(d, b)} + {1'b0, sx} + {16'h0000, cin};
        a.res = fit(sum[15:0], b);
        a.n = msb(a.res, b);
        a.z = (a.res == 16'h0000);
        a.c = b ? sum[8] : sum[16];
        a.v = (msb(d, b) == msb(sx, b)) && (msb(a.res, b) != msb(d, b));
        a.fl = 1'b1;
        a.wr = (op != OP_CMP);
      end
      OP_DSUM: begin
        // nibble-wise decimal sum with carry ripple
        for (int i = 0; i < 4; i++) begin
          nib = {1'b0, d[i*4 +: 4]} + {1'b0, s[i*4 +: 4]} + {4'h0, dc};
          if (nib > 5'd9) begin
            nib = nib + 5'd6;
          end
          a.res[i*4 +: 4] = nib[3:0];
          dc = nib[4];
          if (b && i == 1) begin
            a.c = dc;
          end
        end
        if (!b) begin
          a.c = dc;
        end
        a.res = fit(a.res, b);
        a.n = msb(a.res, b);
        a.z = (a.res == 16'h0000);
        a.fl = 1'b1;
        a.wr = 1'b1;
      end
      OP_TEST: begin
        a = nzc(d & s, b);
        a.wr = 1'b0;
      end
      OP_CLRM: begin
        a.res = fit(d & ~s, b);
        a.wr = 1'b1;
      end
      OP_SETM: begin
        a.res = fit(d | s, b);
        a.wr = 1'b1;
      end
      OP_XOR: begin
        a = nzc(d ^ s, b);
        a.v = msb(d, b) & msb(s, b);
      end
      OP_AND: begin
        a = nzc(d & s, b);
      end
      default: begin
        a = '0;
      end
    endcase
    return a;
  endfunction

  // single-operand evaluation for the in-place group
  function automatic cxe_alu_t single(input logic [2:0] op,
      input logic [15:0] d, input logic ci, input logic b);
    cxe_alu_t a;
    logic [15:0] r;
    a = '0;
    r = fit(d, b);
    case (op)
      SO_ROTC: begin
        r = b ? {8'h00, ci, d[7:1]} : {ci, d[15:1]};
        a = nzc(r, b);
        a.c = d[0];
      end
      SO_ASR: begin
        r = b ? {8'h00, d[7], d[7:1]} : {d[15], d[15:1]};
        a = nzc(r, b);
        a.c = d[0];
      end
      SO_SWAP: begin
        a.res = {d[7:0], d[15:8]};
        a.wr = 1'b1;
      end
      SO_SEXT: begin
        a = nzc({{8{d[7]}}, d[7:0]}, 1'b0);
      end
      default: begin
        a = '0;
      end
    endcase
    return a;
  endfunction

  // cycles per instruction from its fields
  function automatic logic [2:0] cycles(input logic [15:0] ins);
    logic [1:0] as;
    logic dpc, imm, copy_op;
    as = ins[5:4];
    dpc = (ins[3:0] == 4'h0);
    imm = (ins[11:8] == 4'h0);
    copy_op = (ins[15:12] == OP_COPY);
    cycles = 3'h1;
    if (ins[15:13] == FMT_JUMP) begin
      cycles = CYC_JUMP;
    end else if (ins[15:10] == FMT_SINGLE) begin
      case (ins[9:7])
        SO_PUSH: cycles = (as == 2'h0) ? 3'h1 : (as == 2'h1) ? 3'h3 : 3'h2;
        SO_CALL: cycles = (as == 2'h0) ? 3'h2 : (as == 2'h1) ? 3'h4 : 3'h3;
        SO_INTERRUPT_RETURN_OP: cycles = CYC_INTERRUPT_RETURN_OP;
        SO_ROTC, SO_SWAP, SO_ASR, SO_SEXT: begin
          case (as)
            2'h0: cycles = dpc ? 3'h2 : 3'h1;
            2'h1: cycles = 3'h4;
            2'h2: cycles = 3'h3;
            default: cycles = dpc ? 3'h2 : 3'h3;
          endcase
        end
        default: cycles = 3'h1;
      endcase
    end else if (!ins[7]) begin
      case (as)
        2'h0: cycles = dpc ? 3'h2 : 3'h1;
        2'h1: cycles = dpc ? 3'h5 : 3'h4;
        2'h2: cycles = dpc ? 3'h4 : 3'h3;
        default: cycles = imm ? (dpc ? 3'h3 : 3'h2) : (dpc ? 3'h4 : 3'h3);
      endcase
    end else begin
      cycles = (as == 2'h0) ? (copy_op ? 3'h2 : 3'h4) : (copy_op ? 3'h3 : 3'h5);
    end
  endfunction

  // instruction length in bytes, used for the next counter value
  function automatic logic [15:0] ilen(input logic [15:0] ins);
    logic [1:0] n;
    logic [3:0] rs; // operand register: low field in single-operand words
    n = 2'h0;
    rs = (ins[15:14] == 2'h0) ? ins[3:0] : ins[11:8];
    if (ins[15:13] != FMT_JUMP) begin
      if (ins[5:4] == 2'h1 || (ins[5:4] == 2'h3 && rs == 4'h0)) begin
        n = n + 2'h1;
      end
      if (ins[15:14] != 2'h0 && ins[7]) begin
        n = n + 2'h1;
      end
    end
    ilen = {13'h0000, n, 1'b0} + STACK_STEP;
  endfunction

  function automatic logic taken(input logic [2:0] cc, input logic [15:0] sr);
    case (cc)
      3'h0: taken = ~sr[SR_Z];
      3'h1: taken = sr[SR_Z];
      3'h2: taken = ~sr[SR_C];
      3'h3: taken = sr[SR_C];
      3'h4: taken = sr[SR_N];
      3'h5: taken = (sr[SR_N] == sr[SR_V]);
      3'h6: taken = (sr[SR_N] != sr[SR_V]);
      default: taken = 1'b1;
    endcase
  endfunction

  cxe_state_t state_q; // sequencer state
  logic [2:0] cnt_q; // cycles left in the current instruction
  logic run_q; // software run enable
  logic [31:0] count_q; // retired instruction count
  logic [7:0] bus_addr_q; // captured bus address
  logic bus_wr_q; // write data phase pending
  logic entry_q; // entry frame: status word still to store
  logic [15:0] sr_save_q; // status as it stood at entry, sleep dropped
  logic [15:0] pc_d, sp_d, sr_d;
  logic pc_we, sp_we, sr_we;
  logic take; // an operation or entry is taken this cycle
  logic is_irq, is_jmp, is_sgl;
  logic [2:0] sop;
  logic bsel;
  cxe_alu_t alu;

  // decode of the offered instruction
  assign is_irq = i_irq_req & o_sr[SR_GIE];
  assign is_jmp = (i_op_instr[15:13] == FMT_JUMP);
  assign is_sgl = (i_op_instr[15:10] == FMT_SINGLE);
  assign sop = i_op_instr[9:7];
  assign bsel = i_op_instr[6] & ~(is_sgl & (sop == SO_SWAP || sop == SO_SEXT));
  assign take = (state_q == ST_IDLE) & run_q & (i_op_valid | is_irq);
  assign alu = is_sgl ? single(sop, i_op_dst, o_sr[SR_C], bsel) :
               dual(i_op_instr[15:12], i_op_src, i_op_dst, o_sr[SR_C], bsel);

  // next state of counter, stack pointer and status
  always_comb begin
    pc_d = o_pc;
    sp_d = o_sp;
    sr_d = o_sr;
    pc_we = 1'b0;
    sp_we = 1'b0;
    sr_we = 1'b0;
    if (take && is_irq) begin
      // entry pushes counter and status, masks further entries
      pc_d = i_irq_vec;
      sp_d = o_sp - (STACK_STEP + STACK_STEP);
      sr_d = o_sr & ~(16'h0001 << SR_GIE) & ~(16'h0001 << SR_SLEEP);
      {pc_we, sp_we, sr_we} = 3'b111;
    end else if (take && is_jmp) begin
      pc_d = o_pc + STACK_STEP;
      if (taken(i_op_instr[12:10], o_sr)) begin
        pc_d = o_pc + STACK_STEP + {{5{i_op_instr[9]}}, i_op_instr[9:0], 1'b0};
      end
      pc_we = 1'b1;
    end else if (take) begin
      pc_d = o_pc + ilen(i_op_instr);
      pc_we = 1'b1;
      if (is_sgl && (sop == SO_PUSH || sop == SO_CALL)) begin
        sp_d = o_sp - STACK_STEP; // always two
        sp_we = 1'b1;
        if (sop == SO_CALL) begin
          pc_d = i_op_src;
        end
      end else if (is_sgl && sop == SO_INTERRUPT_RETURN_OP) begin
        pc_we = 1'b0;
      end else begin
        if (alu.fl) begin
          sr_d[SR_V] = alu.v;
          sr_d[SR_N] = alu.n;
          sr_d[SR_Z] = alu.z;
          sr_d[SR_C] = alu.c;
          sr_we = 1'b1;
        end
        // destination is one of the registers held here
        if (alu.wr && i_op_instr[3:0] == 4'h0 && (is_sgl || !i_op_instr[7])) begin
          pc_d = alu.res;
        end
        if (alu.wr && i_op_instr[3:0] == 4'h1 && (is_sgl || !i_op_instr[7])) begin
          sp_d = alu.res;
          sp_we = 1'b1;
        end
        if (alu.wr && i_op_instr[3:0] == 4'h2 && (is_sgl || !i_op_instr[7])) begin
          sr_d = alu.res; // mask ops reach single bits
          sr_we = 1'b1;
        end
      end
    end else if (state_q == ST_POP1) begin
      sr_d = i_mem_rdata; // status from stack top
      sp_d = o_sp + STACK_STEP;
      {sr_we, sp_we} = 2'b11;
    end else if (state_q == ST_POP2) begin
      pc_d = i_mem_rdata; // then the counter
      sp_d = o_sp + STACK_STEP;
      {pc_we, sp_we} = 2'b11;
    end
  end

  // sequencer: holds each instruction for its cycle figure
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= ST_IDLE;
      cnt_q <= 3'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take && !is_irq && is_sgl && sop == SO_INTERRUPT_RETURN_OP) begin
            state_q <= ST_POP1;
            cnt_q <= CYC_INTERRUPT_RETURN_OP - 3'h3; // two pop cycles come first
          end else if (take) begin
            cnt_q <= (is_irq ? CYC_IRQ : cycles(i_op_instr)) - 3'h1;
            if ((is_irq ? CYC_IRQ : cycles(i_op_instr)) != 3'h1) begin
              state_q <= ST_BUSY;
            end
          end
        end
        ST_POP1: begin
          state_q <= ST_POP2;
        end
        ST_POP2: begin
          state_q <= ST_BUSY;
        end
        ST_BUSY: begin
          cnt_q <= cnt_q - 3'h1;
          if (cnt_q == 3'h1) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // core state registers, bus writes reach counter and pointer only and yield to the core
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pc <= PC_RST;
      o_sp <= SP_RST;
      o_sr <= SR_RST;
    end else begin
      if (pc_we) begin
        o_pc <= pc_d;
      end else if (bus_wr_q && bus_addr_q == REG_PC) begin
        o_pc <= i_hwdata[15:0];
      end
      if (sp_we) begin
        o_sp <= sp_d;
      end else if (bus_wr_q && bus_addr_q == REG_SP) begin
        o_sp <= i_hwdata[15:0];
      end
      if (sr_we) begin
        o_sr <= sr_d;
      end
    end
  end

  // result write-back to the outer register file
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_res_valid <= 1'b0;
      o_res_we <= 1'b0;
      o_res_reg <= 4'h0;
      o_res_data <= 16'h0000;
    end else begin
      o_res_valid <= take & ~is_irq & ~is_jmp;
      o_res_we <= take & ~is_irq & ~is_jmp & alu.wr;
      o_res_reg <= i_op_instr[3:0];
      o_res_data <= alu.res;
    end
  end

  // data memory: pushes, entry frame and pops
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_mem_addr <= 16'h0000;
      o_mem_wdata <= 16'h0000;
      o_mem_we <= 1'b0;
      o_mem_re <= 1'b0;
      entry_q <= 1'b0;
      sr_save_q <= 16'h0000;
    end else begin
      o_mem_we <= 1'b0;
      o_mem_re <= 1'b0;
      entry_q <= take & is_irq;
      if (take && is_irq) begin
        // frame slot for the counter first; status kept here
        // because the entry clears its enable bit at this same edge
        o_mem_addr <= o_sp - STACK_STEP;
        o_mem_wdata <= o_pc;
        o_mem_we <= 1'b1;
        sr_save_q <= o_sr & ~(16'h0001 << SR_SLEEP);
      end else if (take && is_sgl && sop == SO_PUSH) begin
        o_mem_addr <= o_sp - STACK_STEP;
        o_mem_wdata <= fit(i_op_src, bsel);
        o_mem_we <= 1'b1;
      end else if (take && is_sgl && sop == SO_CALL) begin
        o_mem_addr <= o_sp - STACK_STEP; // return address
        o_mem_wdata <= o_pc + ilen(i_op_instr);
        o_mem_we <= 1'b1;
      end else if (take && is_sgl && sop == SO_INTERRUPT_RETURN_OP) begin
        o_mem_addr <= o_sp;
        o_mem_re <= 1'b1;
      end else if (state_q == ST_POP1) begin
        o_mem_addr <= o_sp + STACK_STEP;
        o_mem_re <= 1'b1;
      end else if (entry_q) begin
        // status saved without the sleep flag
        o_mem_addr <= o_mem_addr - STACK_STEP;
        o_mem_wdata <= sr_save_q;
        o_mem_we <= 1'b1;
      end
    end
  end

  // issue handshake and retired count
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_op_ready <= 1'b0;
      count_q <= 32'h00000000;
    end else begin
      o_op_ready <= run_q & ((state_q == ST_IDLE & ~take) |
                    (state_q == ST_IDLE & take & ~is_irq &
                     cycles(i_op_instr) == 3'h1 & ~(is_sgl & sop == SO_INTERRUPT_RETURN_OP)) |
                    (state_q == ST_BUSY & cnt_q == 3'h1));
      if (take && !is_irq) begin
        count_q <= count_q + 32'h00000001;
      end
    end
  end

  // bus slave: address phase capture, zero wait states
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      bus_addr_q <= 8'h00;
      bus_wr_q <= 1'b0;
      run_q <= CTRL_RUN_RST;
      o_hrdata <= 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      if (bus_wr_q && bus_addr_q == REG_CTRL) begin
        run_q <= i_hwdata[0];
      end
      bus_wr_q <= 1'b0;
      if (i_hsel && i_hready && i_htrans[1]) begin
        bus_addr_q <= i_haddr;
        bus_wr_q <= i_hwrite;
        case (i_haddr)
          REG_CTRL: o_hrdata <= {31'h00000000, run_q};
          REG_SP: o_hrdata <= {16'h0000, o_sp};
          REG_PC: o_hrdata <= {16'h0000, o_pc};
          REG_SR: o_hrdata <= {16'h0000, o_sr};
          REG_COUNT: o_hrdata <= count_q;
          default: o_hrdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// file: design/cxe_pkg.sv
// constants for the instruction execute unit of the 16-bit core
// assumes one system clock and one register bus clocked by it
package cxe_pkg;
  // dual-operand opcodes
  localparam logic [3:0] OP_COPY = 4'h4;
  localparam logic [3:0] OP_SUM = 4'h5;
  localparam logic [3:0] OP_SUMC = 4'h6;
  localparam logic [3:0] OP_DIFB = 4'h7;
  localparam logic [3:0] OP_DIFF = 4'h8;
  localparam logic [3:0] OP_CMP = 4'h9;
  localparam logic [3:0] OP_DSUM = 4'ha;
  localparam logic [3:0] OP_TEST = 4'hb;
  localparam logic [3:0] OP_CLRM = 4'hc;
  localparam logic [3:0] OP_SETM = 4'hd;
  localparam logic [3:0] OP_XOR = 4'he;
  localparam logic [3:0] OP_AND = 4'hf;
  // single-operand codes
  localparam logic [2:0] SO_ROTC = 3'h0;
  localparam logic [2:0] SO_SWAP = 3'h1;
  localparam logic [2:0] SO_ASR = 3'h2;
  localparam logic [2:0] SO_SEXT = 3'h3;
  localparam logic [2:0] SO_PUSH = 3'h4;
  localparam logic [2:0] SO_CALL = 3'h5;
  localparam logic [2:0] SO_INTERRUPT_RETURN_OP = 3'h6;
  // instruction format prefixes
  localparam logic [5:0] FMT_SINGLE = 6'h04;
  localparam logic [2:0] FMT_JUMP = 3'h1;
  // status register bit positions
  localparam int SR_C = 0;
  localparam int SR_Z = 1;
  localparam int SR_N = 2;
  localparam int SR_GIE = 3;
  localparam int SR_SLEEP = 4;
  localparam int SR_V = 8;
  localparam logic [15:0] SR_RST = 16'h0000;
  // stack step and reset values
  localparam logic [15:0] STACK_STEP = 16'h0002;
  localparam logic [15:0] SP_RST = 16'h0000;
  localparam logic [15:0] PC_RST = 16'h0000;
  // register bus byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SP = 8'h04;
  localparam logic [7:0] REG_PC = 8'h08;
  localparam logic [7:0] REG_SR = 8'h0c;
  localparam logic [7:0] REG_COUNT = 8'h10;
  localparam logic CTRL_RUN_RST = 1'b1;
  // cycle figures
  localparam logic [2:0] CYC_JUMP = 3'h2;
  localparam logic [2:0] CYC_INTERRUPT_RETURN_OP = 3'h4;
  localparam logic [2:0] CYC_IRQ = 3'h3;
  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_BUSY = 4'b0010,
    ST_POP1 = 4'b0100,
    ST_POP2 = 4'b1000
  } cxe_state_t;
endpackage

// file: dv/cxe_core_chk.sv
// port checker for the execute unit: takes, results and cycle figures
// assumes it is bound to cxe_core and sees that module's ports only
`timescale 1ns/10ps
module cxe_core_chk
  import cxe_pkg::*;
(
  // clock, reset and issue
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_op_valid,
  input wire logic [15:0] i_op_instr,
  input wire logic [15:0] i_op_src,
  input wire logic [15:0] i_op_dst,
  input wire logic i_irq_req,
  // watched outputs
  input wire logic o_op_ready,
  input wire logic o_res_valid,
  input wire logic o_res_we,
  input wire logic [15:0] o_res_data,
  input wire logic [15:0] o_mem_addr,
  input wire logic [15:0] o_mem_wdata,
  input wire logic o_mem_we,
  input wire logic [15:0] o_pc,
  input wire logic [15:0] o_sp,
  input wire logic [15:0] o_sr
);
  // what is taken at this edge; entry wins over an offer
  logic irq_tk, op_tk, dual, sgl, jmp;
  logic [15:0] tgt;
  assign irq_tk = o_op_ready & i_irq_req & o_sr[SR_GIE];
  assign op_tk = o_op_ready & i_op_valid & ~irq_tk;
  assign dual = op_tk & (i_op_instr[15:14] != 2'b00);
  assign sgl = op_tk & (i_op_instr[15:10] == FMT_SINGLE);
  assign jmp = op_tk & (i_op_instr[15:13] == FMT_JUMP);
  // jump target: doubled signed offset plus two
  assign tgt = o_pc + 16'h0002 + {{5{i_op_instr[9]}}, i_op_instr[9:0], 1'b0};
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  a_copy_flags: assert property (
    dual && i_op_instr[15:12] == OP_COPY |=> $stable({o_sr[8], o_sr[2:0]}))
    else $error("copy moved a flag");
  a_no_write: assert property (
    dual && (i_op_instr[15:12] == OP_CMP || i_op_instr[15:12] == OP_TEST)
    |=> o_res_valid && !o_res_we) else $error("compare or test wrote");
  a_clear_mask: assert property (
    dual && i_op_instr[15:12] == OP_CLRM && !i_op_instr[6]
    |=> o_res_data == $past(i_op_dst & ~i_op_src)) else $error("clear mask");
  a_swap_bytes: assert property (
    sgl && i_op_instr[9:7] == SO_SWAP |=> o_res_data ==
    {$past(i_op_dst[7:0]), $past(i_op_dst[15:8])}) else $error("swap");
  a_push_stack: assert property (
    sgl && i_op_instr[9:7] == SO_PUSH |=> o_mem_we && o_mem_addr == o_sp
    && o_sp == $past(o_sp) - STACK_STEP) else $error("push stack");
  a_reg_pc_two: assert property (
    dual && !i_op_instr[7] && i_op_instr[5:0] == 6'h00
    |=> !o_op_ready ##1 o_op_ready) else $error("reg to pc cycles");
  a_jump_target: assert property (
    jmp && i_op_instr[12:10] == 3'h7 |=> ##1 o_pc == $past(tgt, 2))
    else $error("jump target");
  a_jump_two: assert property (
    jmp |=> !o_op_ready ##1 o_op_ready) else $error("jump cycles");
  a_interrupt_return_op_four: assert property (
    sgl && i_op_instr[9:7] == SO_INTERRUPT_RETURN_OP |=> !o_op_ready [*3] ##1 o_op_ready)
    else $error("return cycles");
  a_entry_stack: assert property (
    irq_tk |=> o_mem_we && o_mem_wdata == $past(o_pc) ##1 o_mem_we &&
    o_mem_wdata == ($past(o_sr, 2) & 16'hffef)) else $error("entry stack");
  a_byte_high: assert property (
    dual && i_op_instr[6] |=> o_res_data[15:8] == 8'h00)
    else $error("byte high bits");
endmodule
bind cxe_core cxe_core_chk u_chk (.*);

// file: dv/cxe_mem.sv
// data memory model on the execute unit's load and store port
// assumes reads answer at once and stores land on the rising edge
`timescale 1ns/10ps
module cxe_mem (
  // clock and port
  input wire logic i_mclk,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_we,
  input wire logic i_re,
  output logic [15:0] o_rdata
);
  // word store, byte bit of the address ignored
  logic [15:0] mem [0:127];
  // store on the edge
  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_addr[7:1]] <= i_wdata;
    end
  end
  // without a read strobe the port shows a wrong word, never a stale one
  assign o_rdata = i_re ? mem[i_addr[7:1]] : ~mem[i_addr[7:1]];
endmodule

// file: dv/tb_cxe_core.sv
// self-checking bench for the execute unit with its memory model
// assumes one 25 MHz clock and a bus whose only slave is the unit
`timescale 1ns/10ps
module tb_cxe_core;
  import cxe_pkg::*;
  // design-side signals, named as the ports
  logic i_mclk = 0, i_rstn = 0, i_hsel = 0, i_hwrite = 0, i_hready;
  logic [7:0] i_haddr = 0;
  logic [1:0] i_htrans = 0;
  logic [2:0] i_hsize = 3'h2;
  logic [31:0] i_hwdata = 0, o_hrdata;
  logic o_hreadyout, o_hresp, i_op_valid = 0, i_irq_req = 0, o_op_ready;
  logic [15:0] i_op_instr = 0, i_op_src = 0, i_op_dst = 0;
  logic [15:0] i_irq_vec = 16'h0300, o_res_data, o_mem_addr, o_mem_wdata;
  logic [15:0] i_mem_rdata, o_pc, o_sp, o_sr;
  logic [3:0] o_res_reg;
  logic o_res_valid, o_res_we, o_mem_we, o_mem_re;
  // bench state
  logic [15:0] w, s, d, r, e, p, t, sp0, pc0, rd;
  logic [7:0] f, tk = 8'hd5;
  logic [9:0] o;
  logic [31:0] q;
  logic we;
  int n, n_errors = 0, check_count = 0;
  // vectors: word, src, dst, result, status, {flag c unknown, writes}
  logic [87:0] tv [0:16] = '{
    88'h4504_0001_7fff_0001_0000_01, 88'h5504_0001_7fff_8000_0104_01,
    88'h6504_0001_ffff_0000_0003_01, 88'h7504_0003_0005_0002_0001_01,
    88'h8504_0005_0003_fffe_0004_01, 88'h9504_0005_0005_0000_0003_00,
    88'ha504_0001_0019_0021_0000_01, 88'hb504_8000_8001_0000_0004_02,
    88'hc504_0f0f_ffff_f0f0_0004_03, 88'hd504_000f_f000_f00f_0004_03,
    88'he504_00ff_00ff_0000_0002_03, 88'hf504_8f00_ff00_8f00_0004_03,
    88'h5544_0001_12ff_0000_0003_01, 88'h1004_0002_0002_8001_0004_01,
    88'h1104_8003_8003_c001_0005_01, 88'h1084_1234_1234_3412_0005_01,
    88'h1184_0080_0080_ff80_0004_03};
  assign i_hready = o_hreadyout;
  cxe_core DUT (.*);
  cxe_mem mem_i (.i_mclk(i_mclk), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata),
    .i_we(o_mem_we), .i_re(o_mem_re), .o_rdata(i_mem_rdata));
  // clock
  initial forever #20 i_mclk = ~i_mclk;
  // verdict and end of run
  task stop_test();
    if (n_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // counted compare
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one single word transfer on the register bus
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] v);
    @(posedge i_mclk);
    i_hsel <= 1'b1;
    i_htrans <= 2'b10;
    i_haddr <= a;
    i_hwrite <= wr;
    do @(posedge i_mclk); while (i_hready !== 1'b1);
    i_hsel <= 1'b0;
    i_htrans <= 2'b00;
    i_hwdata <= v;
    do @(posedge i_mclk); while (i_hready !== 1'b1);
    q = o_hrdata;
  endtask
  // offer one operation or entry, then watch six cycles
  task run(input logic ir, input logic [15:0] iw, is, id);
    logic seen;
    @(posedge i_mclk);
    i_irq_req <= ir;
    i_op_valid <= !ir;
    i_op_instr <= iw;
    i_op_src <= is;
    i_op_dst <= id;
    do @(negedge i_mclk); while (o_op_ready !== 1'b1);
    @(posedge i_mclk);
    i_irq_req <= 1'b0;
    i_op_valid <= 1'b0;
    n = 0;
    seen = 0;
    rd = 'x;
    we = 'x;
    repeat (6) begin
      @(negedge i_mclk);
      if (!seen) n++;
      if (o_op_ready === 1'b1) seen = 1;
      if (o_res_valid === 1'b1) begin
        rd = o_res_data;
        we = o_res_we;
      end
    end
  endtask
  // hang guard
  initial begin
    #200000;
    n_errors++;
    stop_test();
  end
  // main sequence
  initial begin
    repeat (12) @(posedge i_mclk);
    i_rstn <= 1'b1;
    // reset values, unmapped words read zero
    for (int a = 0; a < 9; a++) begin
      bus(0, 8'(a * 4), 0);
      chk(q, a == 0);
    end
    bus(1, REG_SR, 32'hffff);
    bus(0, REG_SR, 0);
    chk(q, 0);
    bus(1, REG_SP, 32'h0080);
    foreach (tv[k]) begin
      {w, s, d, r, e, f} = tv[k];
      run(0, w, s, d);
      chk(n, 1);
      chk(we, f[0]);
      chk(o_res_reg, w[3:0]);
      if (f[0]) chk(rd, r);
      chk(o_sr & (f[1] ? 16'h0106 : 16'h0107), e);
    end
    // jumps over every condition after a compare of 3 against 5
    run(0, 16'h9504, 16'h0005, 16'h0003);
    for (int c = 0; c < 8; c++) begin
      o = c[0] ? 10'h1ff : 10'h200;
      p = o_pc;
      run(0, {3'b001, c[2:0], o}, 16'h0000, 16'h0000);
      t = p + 16'h0002;
      if (tk[c]) t = t + {{5{o[9]}}, o, 1'b0};
      chk(o_pc, t);
      chk(n, 2);
      chk(o_sr, 16'h0004);
    end
    // sum into the counter takes two cycles
    p = o_pc;
    run(0, 16'h5500, 16'h0100, p);
    chk(n, 2);
    chk(o_pc, p + 16'h0100);
    // stack store, byte store, subroutine entry
    run(0, 16'h1205, 16'hbeef, 16'hbeef);
    chk(o_sp, 16'h007e);
    chk(mem_i.mem[63], 16'hbeef);
    run(0, 16'h1245, 16'h12ab, 16'h12ab);
    chk(o_sp, 16'h007c);
    chk(mem_i.mem[62], 16'h00ab);
    run(0, 16'h1285, 16'h0400, 16'h0400);
    chk(o_pc, 16'h0400);
    chk(o_sp, 16'h007a);
    chk(n, 2);
    // status bits by mask, then sleep
    run(0, 16'hd502, 16'h000f, o_sr);
    chk(o_sr[3:0], 4'hf);
    run(0, 16'hc502, 16'h0005, o_sr);
    chk(o_sr[3:0], 4'ha);
    run(0, 16'hd502, 16'h0010, o_sr);
    // entry drops sleep from the saved status, return restores the rest
    pc0 = o_pc;
    sp0 = o_sp;
    run(1, 0, 0, 0);
    chk(n, 3);
    chk(o_pc, i_irq_vec);
    chk(o_sp, sp0 - 16'h0004);
    chk(mem_i.mem[(sp0 - 16'h0002) >> 1], pc0);
    chk(mem_i.mem[(sp0 - 16'h0004) >> 1], 16'h000a);
    run(0, 16'h1300, 0, 0);
    chk(n, 4);
    chk(o_sr, 16'h000a);
    chk(o_pc, pc0);
    chk(o_sp, sp0);
    stop_test();
  end
endmodule
